// ==== inc/auto_serial_pkg.sv ====
// Function
// - Disable idles pins, resets count, trigger, shift, status flags
// - Buffer access refused while port disabled
// - Buffer contents kept across disable (buffer has no reset)
// - Auto bit picks single-byte or buffer mode
// - Single stops at end point; repeat wraps
// - Master bit picks internal or external clock
// - Transmit disabled holds data output low
// - Receive bit gates capture; order bit picks first
// - Mode and status reset to zero, writable
// - Base clock is oscillator or half of it
// - Strobe output only in master mode
// - Strobe adds two clocks between bytes
// - Busy detection waits while busy active
// - Busy level bit sets active busy polarity
// - Busy during data bits sets error flag
// - Error flag cleared by reset, disable, start
// - Status flag high from start to end
// - Error and status flags are read-only
// - Buffer writable during automatic transfer
// - Triggers act per byte, cleared after done
// - Master waits interval, then signals done
package auto_serial_pkg;
  localparam int WB_AW = 18;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_MODE = 16'hff90;
  localparam logic [15:0] IDX_STAT = 16'hff91;
  localparam logic [15:0] IDX_TRIG = 16'hff92;
  localparam logic [15:0] IDX_DIV = 16'hff93;
  localparam logic [15:0] IDX_ENDP = 16'hff94;
  localparam logic [15:0] IDX_IVAL = 16'hff95;
  localparam logic [15:0] IDX_SHIFT = 16'hff96;
  localparam logic [15:0] IDX_ADDR = 16'hff97;
  localparam logic [15:0] IDX_RAM = 16'hfa00;
  // Mode register fields
  localparam int MB_EN = 7;
  localparam int MB_AUTO = 6;
  localparam int MB_RPT = 5;
  localparam int MB_MST = 4;
  localparam int MB_TXE = 3;
  localparam int MB_RXE = 2;
  localparam int MB_DIR = 1;
  // Status and trigger register fields
  localparam int SB_CKS = 6;
  localparam int SB_STB = 5;
  localparam int SB_BSY = 4;
  localparam int SB_LVL = 3;
  localparam int SB_ERE = 2;
  localparam int TB_STP = 1;
  localparam int TB_STA = 0;
  // Writable bits and reset values
  localparam logic [7:0] MODE_WMASK = 8'hfe;
  localparam logic [7:0] STAT_WMASK = 8'h7c;
  localparam logic [7:0] TRIG_WMASK = 8'h03;
  localparam logic [7:0] DIV_WMASK = 8'h03;
  localparam logic [7:0] ENDP_WMASK = 8'h1f;
  localparam logic [7:0] IVAL_WMASK = 8'h3f;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h03;
  // Timing in transfer clocks and divider half periods
  localparam logic [7:0] STROBE_CLKS = 8'h02;
  localparam logic [7:0] BUSY_CLKS = 8'h01;
  localparam logic [7:0] TICKS_PER_CLK = 8'h02;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0][5:0] HALF_DIV = {6'h10, 6'h08, 6'h04, 6'h03};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_GAP = 2'b10,
    ST_DONE = 2'b11
  } eng_state_e;

  typedef struct packed {
    logic [15:0] idx;
    logic [7:0] dat;
    logic sel;
    logic we;
  } wb_req_s;
endpackage : auto_serial_pkg

// ==== design/auto_serial_sync.sv ====
module auto_serial_sync
  import auto_serial_pkg::*;
#(
  parameter int W = 3
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // Two flops per pin input
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_r;
    logic sync_r;
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
      end else begin
        meta_r <= d_i[i];
        sync_r <= meta_r;
      end
    end
    assign q_o[i] = sync_r;
  end
endmodule : auto_serial_sync

// ==== design/auto_serial_baud.sv ====
module auto_serial_baud
  import auto_serial_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic half_base_i,
  input wire logic [1:0] div_sel_i,
  output logic tick_o
);
  logic [5:0] cnt_r;
  logic [5:0] reload;

  // Half serial period in system clocks
  assign reload = (HALF_DIV[div_sel_i] << half_base_i) - 6'h01;
  assign tick_o = run_i && (cnt_r == 6'h00);

  // Down counter, reloaded when idle or on tick
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= 6'h00;
    end else if (!run_i || tick_o) begin
      cnt_r <= reload;
    end else begin
      cnt_r <= cnt_r - 6'h01;
    end
  end

  AST_TICK_SPACING: assert property (@(posedge clk_i) disable iff (!nrst_i)
    run_i && tick_o |=> !tick_o)
    else $error("Divider ticks on back-to-back cycles");
endmodule : auto_serial_baud

// ==== design/auto_serial_port.sv ====
module auto_serial_port
  import auto_serial_pkg::*;
#(
  parameter int RAM_DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [WB_AW-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire logic serial_data_in_i,
  input wire logic serial_clock_pin_i,
  input wire logic busy_input_pin_i,
  output logic serial_data_out_pin_o,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n_o,
  output logic strobe_o,
  output logic transfer_done_interrupt_o
);
  localparam int RAW = $clog2(RAM_DEPTH);

  logic [7:0] mode_r, stat_r, div_r, endp_r, ival_r;
  logic [7:0] trig_r, trig_nxt, sh_r, sh_nxt, rdata_r;
  logic [RAW-1:0] addr_r, addr_nxt;
  logic tsf_r, tsf_nxt, err_r, err_nxt;
  logic sck_r, sck_nxt, so_r, so_nxt;
  logic done_r, done_nxt, strobe_r, strobe_nxt;
  logic sck_prev_r, resp_r, ok_r;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] gap_cnt_r, gap_cnt_nxt;
  eng_state_e state_r, state_nxt;
  logic [7:0] ram [RAM_DEPTH];
  logic [2:0] sync_q;
  logic s_si, s_sck, s_busy, tick;

  // Bus request carrier
  wb_req_s req;
  assign req = '{idx: adr_i[WB_AW-1:2], dat: dat_i[7:0],
                 sel: sel_i[0], we: we_i};

  // Address decode
  logic bus_req, port_en, ok, wr;
  logic hit_mode, hit_stat, hit_trig, hit_div, hit_endp;
  logic hit_ival, hit_shift, hit_addr, hit_ram;
  logic [RAW-1:0] ram_idx;
  assign bus_req = cyc_i && stb_i;
  assign hit_mode = req.idx == IDX_MODE;
  assign hit_stat = req.idx == IDX_STAT;
  assign hit_trig = req.idx == IDX_TRIG;
  assign hit_div = req.idx == IDX_DIV;
  assign hit_endp = req.idx == IDX_ENDP;
  assign hit_ival = req.idx == IDX_IVAL;
  assign hit_shift = req.idx == IDX_SHIFT;
  assign hit_addr = req.idx == IDX_ADDR;
  assign hit_ram = req.idx[15:RAW] == IDX_RAM[15:RAW];
  assign ram_idx = req.idx[RAW-1:0];
  assign port_en = mode_r[MB_EN];
  assign ok = hit_mode || hit_stat || hit_trig || hit_div || hit_endp
    || hit_ival || hit_shift || hit_addr
    || (hit_ram && port_en);
  // Writes land on the edge that sees ack high
  assign wr = bus_req && resp_r && ok && req.we && req.sel;

  // Mode and status bits
  logic auto_on, rpt_on, master, txe, rxe, lsb_first;
  logic err_en, busy_en, strobe_on, busy_act, busy_hold;
  assign auto_on = mode_r[MB_AUTO];
  assign rpt_on = mode_r[MB_RPT];
  assign master = mode_r[MB_MST];
  assign txe = mode_r[MB_TXE];
  assign rxe = mode_r[MB_RXE];
  assign lsb_first = mode_r[MB_DIR];
  assign err_en = stat_r[SB_ERE];
  assign busy_en = stat_r[SB_BSY];
  assign strobe_on = stat_r[SB_STB] && master;
  assign busy_act = s_busy == stat_r[SB_LVL];
  assign busy_hold = busy_en && busy_act;

  // Read selection
  logic [7:0] stat_view, rd_byte;
  assign stat_view = {1'b0, stat_r[6:2], err_r, tsf_r};
  assign rd_byte = hit_mode ? mode_r
    : hit_stat ? stat_view
    : hit_trig ? trig_r
    : hit_div ? div_r
    : hit_endp ? endp_r
    : hit_ival ? ival_r
    : hit_shift ? sh_r
    : hit_addr ? 8'(addr_r)
    : (hit_ram && port_en) ? ram[ram_idx]
    : 8'h00;

  // Engine reset: chip reset or port disabled
  logic eng_rst_n;
  assign eng_rst_n = nrst_i && port_en;

  // Pin inputs through two flops
  auto_serial_sync #(
    .W(3)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i({serial_data_in_i, serial_clock_pin_i, busy_input_pin_i}),
    .q_o(sync_q)
  );
  assign s_si = sync_q[2];
  assign s_sck = sync_q[1];
  assign s_busy = sync_q[0];

  // Transfer clock divider, master only
  logic baud_run;
  assign baud_run = master
    && (state_r == ST_SHIFT || state_r == ST_GAP);
  auto_serial_baud u_baud (
    .clk_i(clk_i),
    .nrst_i(eng_rst_n),
    .run_i(baud_run),
    .half_base_i(stat_r[SB_CKS]),
    .div_sel_i(div_r[1:0]),
    .tick_o(tick)
  );

  // Serial clock edges from divider or from the pin
  logic ev_fall, ev_rise;
  assign ev_fall = master ? (tick && sck_r)
    : (sck_prev_r && !s_sck);
  assign ev_rise = master ? (tick && !sck_r)
    : (!sck_prev_r && s_sck);

  // Shift path and bit order
  logic rx_bit, cur_bit;
  logic [7:0] sh_shift;
  assign rx_bit = rxe && s_si;
  assign cur_bit = lsb_first ? sh_r[0] : sh_r[7];
  assign sh_shift = lsb_first ? {rx_bit, sh_r[7:1]}
    : {sh_r[6:0], rx_bit};

  // Byte sequencing
  logic at_end, stop_now, start_single, start_auto, trig_wr, eng_wr;
  logic [RAW-1:0] next_addr;
  logic [7:0] gap_clks, gap_ticks;
  assign at_end = addr_r == endp_r[RAW-1:0];
  assign stop_now = !auto_on || trig_r[TB_STP]
    || (at_end && !rpt_on);
  assign next_addr = at_end ? '0 : addr_r + RAW'(1);
  assign trig_wr = wr && hit_trig && auto_on;
  assign start_single = wr && hit_shift && !auto_on && port_en
    && state_r == ST_IDLE;
  assign start_auto = auto_on && trig_r[TB_STA]
    && state_r == ST_IDLE;
  assign gap_clks = !master ? 8'h00
    : ival_r + (strobe_on ? STROBE_CLKS : 8'h00)
    + (busy_en ? BUSY_CLKS : 8'h00);
  assign gap_ticks = {gap_clks[6:0], 1'b0};
  assign eng_wr = state_r == ST_DONE && auto_on && rxe;

  // Engine next state
  always_comb begin
    state_nxt = state_r;
    sh_nxt = sh_r;
    tsf_nxt = tsf_r;
    err_nxt = err_r;
    bit_cnt_nxt = bit_cnt_r;
    sck_nxt = sck_r;
    gap_cnt_nxt = gap_cnt_r;
    addr_nxt = addr_r;
    trig_nxt = trig_wr ? (req.dat & TRIG_WMASK) : trig_r;
    done_nxt = 1'b0;
    so_nxt = !txe ? 1'b0
      : (state_r == ST_SHIFT) ? cur_bit : so_r;
    strobe_nxt = strobe_on && state_r == ST_GAP
      && gap_cnt_r < TICKS_PER_CLK;
    case (state_r)
      ST_IDLE: begin
        sck_nxt = 1'b1;
        if (start_single || start_auto) begin
          sh_nxt = start_single ? req.dat : ram[addr_r];
          tsf_nxt = 1'b1;
          err_nxt = 1'b0;
          bit_cnt_nxt = 3'h0;
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (err_en && busy_act) begin
          err_nxt = 1'b1;
        end
        if (ev_fall) begin
          sck_nxt = 1'b0;
        end
        if (ev_rise) begin
          sck_nxt = 1'b1;
          sh_nxt = sh_shift;
          bit_cnt_nxt = bit_cnt_r + 3'h1;
          if (bit_cnt_r == LAST_BIT) begin
            gap_cnt_nxt = 8'h00;
            state_nxt = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        if (tick) begin
          gap_cnt_nxt = gap_cnt_r + 8'h01;
        end
        if (gap_cnt_r >= gap_ticks && !busy_hold) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        done_nxt = 1'b1;
        if (!trig_wr) begin
          trig_nxt = 8'h00;
        end
        if (stop_now) begin
          tsf_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end else begin
          addr_nxt = next_addr;
          sh_nxt = ram[next_addr];
          bit_cnt_nxt = 3'h0;
          state_nxt = ST_SHIFT;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Engine flops, cleared while the port is off
  always_ff @(posedge clk_i or negedge eng_rst_n) begin
    if (!eng_rst_n) begin
      state_r <= ST_IDLE;
      sh_r <= 8'h00;
      tsf_r <= 1'b0;
      err_r <= 1'b0;
      trig_r <= 8'h00;
      addr_r <= '0;
      bit_cnt_r <= 3'h0;
      sck_r <= 1'b1;
      so_r <= 1'b0;
      gap_cnt_r <= 8'h00;
      done_r <= 1'b0;
      strobe_r <= 1'b0;
      sck_prev_r <= 1'b1; // Pin idles high
    end else begin
      state_r <= state_nxt;
      sh_r <= sh_nxt;
      tsf_r <= tsf_nxt;
      err_r <= err_nxt;
      trig_r <= trig_nxt;
      addr_r <= addr_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      sck_r <= sck_nxt;
      so_r <= so_nxt;
      gap_cnt_r <= gap_cnt_nxt;
      done_r <= done_nxt;
      strobe_r <= strobe_nxt;
      sck_prev_r <= s_sck;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r <= REG_RST;
      stat_r <= REG_RST;
      div_r <= DIV_RST;
      endp_r <= REG_RST;
      ival_r <= REG_RST;
    end else if (wr) begin
      if (hit_mode) mode_r <= req.dat & MODE_WMASK;
      if (hit_stat) stat_r <= req.dat & STAT_WMASK;
      if (hit_div) div_r <= req.dat & DIV_WMASK;
      if (hit_endp) endp_r <= req.dat & ENDP_WMASK;
      if (hit_ival) ival_r <= req.dat & IVAL_WMASK;
    end
  end

  // Buffer, no reset; received bytes beat bus writes
  always_ff @(posedge clk_i) begin
    if (eng_wr) begin
      ram[addr_r] <= sh_r;
    end else if (wr && hit_ram) begin
      ram[ram_idx] <= req.dat;
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_r <= 1'b0;
      ok_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      resp_r <= bus_req && !resp_r;
      ok_r <= ok;
      rdata_r <= rd_byte;
    end
  end

  // Outputs
  assign dat_o = {24'h000000, rdata_r};
  assign ack_o = resp_r && ok_r;
  assign err_o = resp_r && !ok_r;
  assign serial_data_out_pin_o = so_r;
  assign serial_clock_pin_o = sck_r;
  assign serial_clock_pin_oe_n_o = !master;
  assign strobe_o = strobe_r;
  assign transfer_done_interrupt_o = done_r;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_DISABLED_PINS: assert property (
    !port_en |-> !serial_data_out_pin_o && serial_clock_pin_o && !tsf_r)
    else $error("Disabled port does not idle its pins");
  AST_RAM_REFUSED: assert property (
    bus_req && !resp_r && hit_ram && !port_en |=> err_o && !ack_o)
    else $error("Buffer access not refused while disabled");
  AST_TX_OFF_LOW: assert property (
    !txe [*2] |-> !serial_data_out_pin_o)
    else $error("Data output not low with transmit off");
  AST_FLAGS_RO: assert property (
    wr && hit_stat && state_r == ST_IDLE && !start_auto |=> !tsf_r)
    else $error("Status write changed transfer flag");
  AST_START_CLR_ERR: assert property (
    (start_single || start_auto) |=> tsf_r && !err_r
      && state_r == ST_SHIFT)
    else $error("Start did not clear error and raise busy flag");
  AST_STROBE_GAP: assert property (
    state_r == ST_GAP && state_nxt == ST_DONE && strobe_on
      |-> gap_cnt_r >= STROBE_CLKS * TICKS_PER_CLK)
    else $error("Strobe gap shorter than two clocks");
  AST_TRIG_CLEAR: assert property (
    state_r == ST_DONE && !trig_wr |=> trig_r == 8'h00 && done_r)
    else $error("Triggers not cleared with done pulse");
  AST_SINGLE_END: assert property (
    state_r == ST_DONE && auto_on && !rpt_on && at_end
      && !trig_r[TB_STP] |=> !tsf_r && addr_r == $past(addr_r))
    else $error("Single mode did not stop at end point");
  AST_REPEAT_WRAP: assert property (
    state_r == ST_DONE && auto_on && rpt_on && at_end
      && !trig_r[TB_STP] |=> tsf_r && addr_r == '0)
    else $error("Repeat mode did not wrap the count");
  AST_SLAVE_NO_STB: assert property (
    !master ##1 !master |-> !strobe_o)
    else $error("Strobe driven in slave mode");
  AST_BUSY_HOLD: assert property (
    state_r == ST_GAP && busy_hold |=> state_r != ST_DONE)
    else $error("Left wait while busy active");
  AST_BIT_ERR: assert property (
    state_r == ST_SHIFT && err_en && busy_act && port_en
      |=> err_r || !port_en)
    else $error("Busy during data bits not flagged");
  AST_NEXT_ADDR: assert property (
    state_r == ST_DONE && !stop_now |=> addr_r == $past(next_addr))
    else $error("Address count not advanced after byte");

  COV_SINGLE: cover property (start_single ##[1:600] done_r);
  COV_AUTO_RPT: cover property (
    state_r == ST_DONE && auto_on && rpt_on && at_end);
  COV_BIT_ERR: cover property ($rose(err_r));
endmodule : auto_serial_port

// ==== tb/serial_peer.sv ====
module serial_peer #(
  parameter logic [7:0] REPLY = 8'h3c
) (
  input wire logic nrst_i,
  input wire logic sck_i,
  input wire logic sdo_i,
  input wire logic busy_req_i,
  output logic sdi_o,
  output logic busy_o,
  output logic [7:0] rx_o,
  output int bytes_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic [2:0] cnt;
  // Capture on rising clock, whole byte after eight rises
  always @(posedge sck_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 3'h0;
      sh <= 8'h00;
      rx_o <= 8'h00;
      bytes_o <= 0;
    end else begin
      sh <= {sh[6:0], sdo_i};
      cnt <= cnt + 3'h1;
      if (cnt == 3'h7) begin
        rx_o <= {sh[6:0], sdo_i};
        bytes_o <= bytes_o + 1;
      end
    end
  end
  // Reply bits change on falling clock, MSB first
  always @(negedge sck_i or negedge nrst_i) begin
    if (!nrst_i) sdi_o <= REPLY[7];
    else sdi_o <= REPLY[3'h7 - cnt];
  end
  // Busy is asserted high on request
  assign busy_o = busy_req_i;
endmodule : serial_peer

// ==== tb/auto_serial_port_tb_top.sv ====
module auto_serial_port_tb_top;
  import auto_serial_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [WB_AW-1:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] dat_o;
  logic ack, err, sdi, sdo, sck_o, sck_oe_n, strobe, done, busy;
  logic busy_req = 1'b0, ext_sck = 1'b1;
  logic sck_w, so_seen;
  logic [7:0] peer_rx, q;
  int peer_bytes, error_cnt = 0, samples_checked = 0, strobe_cyc, cycles = 0;
  always #20 clk = ~clk;
  // Clock wire from the port as master, from the bench as slave
  assign sck_w = sck_oe_n ? ext_sck : sck_o;
  auto_serial_port dut_u (.clk_i(clk), .nrst_i(nrst), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(4'h1),
    .dat_o(dat_o), .ack_o(ack), .err_o(err), .serial_data_in_i(sdi),
    .serial_clock_pin_i(sck_w), .busy_input_pin_i(busy),
    .serial_data_out_pin_o(sdo), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe_n_o(sck_oe_n), .strobe_o(strobe),
    .transfer_done_interrupt_o(done));
  serial_peer peer_u (.nrst_i(nrst), .sck_i(sck_w), .sdo_i(sdo),
    .busy_req_i(busy_req), .sdi_o(sdi), .busy_o(busy), .rx_o(peer_rx),
    .bytes_o(peer_bytes));
  // Strobe width and data-out activity monitors, plus hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (strobe === 1'b1) strobe_cyc <= strobe_cyc + 1;
    if (sdo !== 1'b0) so_seen <= 1'b1;
    if (cycles > 40000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One classic cycle; returns read byte and error response
  task automatic wb(input logic w, input logic [15:0] idx,
                    input logic [7:0] d, output logic [7:0] r,
                    output logic e);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (!(ack === 1'b1 || err === 1'b1) && n < 50);
    r = dat_o[7:0];
    e = err;
    if (n >= 50) error_cnt++;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Let the ack edge settle before callers look at outputs
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic e;
    wb(1'b1, idx, d, q, e);
  endtask : wr
  task automatic rd(input logic [15:0] idx, output logic [7:0] r);
    logic e;
    wb(1'b0, idx, 8'h00, r, e);
  endtask : rd
  task automatic rd_err(input logic [15:0] idx, output logic e);
    wb(1'b0, idx, 8'h00, q, e);
  endtask : rd_err
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) error_cnt++;
    @(posedge clk);
  endtask : wait_done
  // Far-side clock for slave transfers; stands high between frames
  task automatic slave_clock();
    repeat (8) begin
      repeat (4) @(posedge clk);
      ext_sck <= 1'b0;
      repeat (4) @(posedge clk);
      ext_sck <= 1'b1;
    end
  endtask : slave_clock
  task automatic send(input logic [7:0] d);
    strobe_cyc = 0;
    so_seen = 1'b0;
    wr(IDX_SHIFT, d);
    wait_done();
  endtask : send
  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  logic e;
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(IDX_MODE, q); check(q, 8'h00);
    rd(IDX_STAT, q); check(q, 8'h00);
    rd(IDX_DIV, q); check(q, DIV_RST);
    check(sdo, 1'b0);
    check(sck_w, 1'b1);
    rd_err(16'hff00, e); check(e, 1'b1);
    rd_err(IDX_RAM, e); check(e, 1'b1);
    wr(IDX_STAT, 8'h7f);
    rd(IDX_STAT, q); check(q, 8'h7c);
    wr(IDX_STAT, 8'h20);
    wr(IDX_DIV, 8'h00);
    // Master, tx and rx on, MSB first, strobe enabled
    wr(IDX_MODE, 8'h9c);
    check(sck_oe_n, 1'b0);
    wr(IDX_SHIFT, 8'ha5);
    rd(IDX_STAT, q); check(q[0], 1'b1);
    wait_done();
    rd(IDX_STAT, q); check(q[1:0], 2'b00);
    check(peer_rx, 8'ha5);
    rd(IDX_SHIFT, q); check(q, 8'h3c);
    send(8'h00);
    check(strobe_cyc, 2 * 3 * TICKS_PER_CLK / 2);
    // LSB first
    wr(IDX_MODE, 8'h9e);
    send(8'h01);
    check(peer_rx, 8'h80);
    // Transmit off keeps data out low
    wr(IDX_MODE, 8'h94);
    send(8'hff);
    check(so_seen, 1'b0);
    // Busy active high during data bits sets error flag
    wr(IDX_MODE, 8'h9c);
    wr(IDX_STAT, 8'h0c);
    busy_req <= 1'b1;
    send(8'h5a);
    rd(IDX_STAT, q); check(q, 8'h0e);
    busy_req <= 1'b0;
    send(8'h5a);
    rd(IDX_STAT, q); check(q, 8'h0c);
    // Busy wait holds the gap open until busy drops
    wr(IDX_STAT, 8'h18);
    busy_req <= 1'b1;
    wr(IDX_SHIFT, 8'h5a);
    repeat (200) @(posedge clk);
    rd(IDX_STAT, q); check(q[0], 1'b1);
    busy_req <= 1'b0;
    wait_done();
    rd(IDX_STAT, q); check(q, 8'h18);
    // Slave mode ignores the strobe bit
    wr(IDX_STAT, 8'h20);
    wr(IDX_MODE, 8'h8c);
    check(sck_oe_n, 1'b1);
    check(strobe, 1'b0);
    strobe_cyc = 0;
    wr(IDX_SHIFT, 8'h96);
    slave_clock();
    wait_done();
    check(peer_rx, 8'h96);
    check(strobe_cyc, 0);
    rd(IDX_SHIFT, q); check(q, 8'h3c);
    // Automatic two-byte transfer from the buffer
    wr(IDX_STAT, 8'h00);
    wr(IDX_MODE, 8'hdc);
    wr(IDX_RAM, 8'h11);
    wr(IDX_RAM + 16'h1, 8'h22);
    wr(IDX_ENDP, 8'h01);
    wr(IDX_TRIG, 8'h01);
    wait_done();
    wr(IDX_RAM + 16'h2, 8'h77);
    wait_done();
    repeat (3) @(posedge clk);
    check(peer_rx, 8'h22);
    rd(IDX_STAT, q); check(q[0], 1'b0);
    rd(IDX_TRIG, q); check(q[1:0], 2'b00);
    rd(IDX_RAM, q); check(q, 8'h3c);
    rd(IDX_RAM + 16'h2, q); check(q, 8'h77);
    rd(IDX_ADDR, q); check(q, 8'h01);
    check(peer_bytes, 10);
    // Repeat mode wraps past the end point until stopped
    wr(IDX_RAM + 16'h1, 8'h81);
    wr(IDX_MODE, 8'hf8);
    wr(IDX_TRIG, 8'h01);
    wait_done();
    rd(IDX_STAT, q); check(q[0], 1'b1);
    wait_done();
    wr(IDX_TRIG, 8'h02);
    wait_done();
    rd(IDX_STAT, q); check(q[0], 1'b0);
    rd(IDX_ADDR, q); check(q, 8'h01);
    check(peer_rx, 8'h81);
    // Disable idles the pins and refuses the buffer
    wr(IDX_MODE, 8'h08);
    check(sdo, 1'b0);
    check(sck_w, 1'b1);
    rd(IDX_ADDR, q); check(q, 8'h00);
    rd_err(IDX_RAM, e); check(e, 1'b1);
    // Reprogram before enabling again
    wr(IDX_DIV, 8'h00);
    wr(IDX_MODE, 8'h9c);
    send(8'hc3);
    check(peer_rx, 8'hc3);
    print_verdict();
  end
endmodule : auto_serial_port_tb_top
